// ---- common/p3c_pkg.sv ----
// Constants for the four-pin port control block: register indexes, field positions and reset values.
// Assumes an APB slave with 32-bit data where each register takes one aligned word.
`default_nettype none

package p3c_pkg;

  localparam int unsigned PIN_COUNT = 4;
  localparam int unsigned CTRL_WIDTH = 4;
  localparam int unsigned ADDR_WIDTH = 8;

  // Register indexes; the byte address is four times the index.
  localparam logic [5:0] PIN0_CONTROL_IDX = 6'h14;
  localparam logic [5:0] PIN1_CONTROL_IDX = 6'h15;
  localparam logic [5:0] PIN2_CONTROL_IDX = 6'h16;
  localparam logic [5:0] PIN3_CONTROL_IDX = 6'h17;
  localparam logic [5:0] IRQ_STATUS_IDX = 6'h18;
  localparam logic [5:0] IRQ_CLEAR_IDX = 6'h19;
  localparam logic [5:0] IRQ_ENABLE_IDX = 6'h1a;
  localparam logic [5:0] PIN_LEVEL_IDX = 6'h1b;
  localparam logic [5:0] PIN_OUT_DATA_IDX = 6'h1c;

  // Field positions inside each pin control register.
  localparam int unsigned PAD_TYPE_BIT = 0;
  localparam int unsigned DIRECTION_BIT = 1;
  localparam int unsigned SAMPLE_CLOCK_SELECT_BIT = 2;
  localparam int unsigned SERIAL_RX_PIN_SELECT_BIT = 2;
  localparam int unsigned IRQ_ENABLE_BIT = 3;

  // The pin whose bit 2 selects the serial receive function instead of a sampling clock.
  localparam int unsigned SERIAL_PIN = 3;

  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [3:0] OUT_DATA_RESET = 4'h0;
  localparam logic SERIAL_IDLE_LEVEL = 1'h1;

endpackage

`default_nettype wire

// ---- rtl/p3c_pin_sync.sv ----
// One pin's input path: three-flop synchroniser, agreement filter, and sampled-level change detector.
// Assumes sample_en is on pclk, either a single-cycle tick or held high to sample every cycle; the pin is asynchronous to pclk.
`default_nettype none

module p3c_pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_async,
  input wire logic sample_en,
  output logic level,
  output logic changed
);

  logic meta_q;
  logic mid_q;
  logic late_q;
  logic filt_q;
  logic filt_d;
  logic samp_q;
  logic samp_d;

  // A change is accepted only once the second and third stages agree.
  always_comb begin
    filt_d = (mid_q == late_q) ? late_q : filt_q;
    samp_d = sample_en ? filt_q : samp_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'h0;
      mid_q <= 1'h0;
      late_q <= 1'h0;
      filt_q <= 1'h0;
      samp_q <= 1'h0;
    end else begin
      meta_q <= pin_async;
      mid_q <= meta_q;
      late_q <= mid_q;
      filt_q <= filt_d;
      samp_q <= samp_d;
    end
  end

  assign level = filt_q;
  // The sampled copy runs even while interrupts are off, so enabling later sees no stale edge.
  assign changed = sample_en & (filt_q != samp_q);

endmodule

`default_nettype wire

// ---- rtl/p3c_port.sv ----
// Four-pin general purpose port: per-pin write-only control registers, pad drive, and pin-change interrupts.
// Assumes an APB master on pclk, a one-cycle 64 Hz tick from the time-base on pclk, and external pads.
//
// Behaviour
// - Each pin has its own 4-bit control register, writable only, reads give zero.
// - Bit 3 enables the pin's external interrupt; reset value zero.
// - Pins 0 to 2, bit 2 picks interrupt sampling: 0 tick of 64 Hz, 1 system clock.
// - Pin 3 bit 2 selects the serial receive function instead of a sampling clock.
// - Serial select set forces pin 3 to input and feeds the serial receiver.
// - Bit 1 sets direction: 0 input, 1 output; reset input.
// - In input mode bit 0 chooses pull resistor (0) or high impedance (1).
// - In output mode bit 0 chooses push-pull (0) or open-drain low-only (1).
// - Enabled input pins raise an interrupt on every sampled level change.
// - Pin 3 interrupt input is always sampled on the 64 Hz tick.
//
// The APB register port was chosen for this implementation.
`default_nettype none

module p3c_port #(
  parameter int unsigned PINS = p3c_pkg::PIN_COUNT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [p3c_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PINS-1:0] pin_in,
  input wire logic tick_64hz,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  output logic [PINS-1:0] pin_pull_en,
  output logic serial_rx_data,
  output logic irq
);

  // Control registers, output data and interrupt state.
  logic [p3c_pkg::CTRL_WIDTH-1:0] ctrl_q [PINS];
  logic [p3c_pkg::CTRL_WIDTH-1:0] ctrl_d [PINS];
  logic [PINS-1:0] out_data_q;
  logic [PINS-1:0] out_data_d;
  logic [PINS-1:0] irq_en_q;
  logic [PINS-1:0] irq_en_d;
  logic [PINS-1:0] irq_stat_q;
  logic [PINS-1:0] irq_stat_d;

  // Bus answer registers.
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;

  // Pad and event output registers.
  logic [PINS-1:0] pin_out_q;
  logic [PINS-1:0] pin_out_d;
  logic [PINS-1:0] pin_oe_q;
  logic [PINS-1:0] pin_oe_d;
  logic [PINS-1:0] pull_q;
  logic [PINS-1:0] pull_d;
  logic srx_q;
  logic srx_d;
  logic irq_q;
  logic irq_d;

  // Per-pin derived signals.
  logic [PINS-1:0] level;
  logic [PINS-1:0] changed;
  logic [PINS-1:0] sample_en;
  logic [PINS-1:0] is_input;
  logic [PINS-1:0] event_hit;

  // Decoded bus request.
  logic setup_phase;
  logic write_strobe;
  logic [5:0] reg_idx;
  logic idx_mapped;
  logic addr_aligned;
  logic serial_sel;

  assign setup_phase = psel & ~penable;
  // A write takes effect only at the edge where the master sees pready high.
  assign write_strobe = psel & penable & pwrite & pready_q;
  assign reg_idx = paddr[7:2];
  assign addr_aligned = (paddr[1:0] == 2'h0);
  // Taken from the next state so the receive path and the forced input switch at the same edge.
  assign serial_sel = ctrl_d[p3c_pkg::SERIAL_PIN][p3c_pkg::SERIAL_RX_PIN_SELECT_BIT];

  always_comb begin
    unique case (reg_idx)
      p3c_pkg::PIN0_CONTROL_IDX,
      p3c_pkg::PIN1_CONTROL_IDX,
      p3c_pkg::PIN2_CONTROL_IDX,
      p3c_pkg::PIN3_CONTROL_IDX,
      p3c_pkg::IRQ_STATUS_IDX,
      p3c_pkg::IRQ_CLEAR_IDX,
      p3c_pkg::IRQ_ENABLE_IDX,
      p3c_pkg::PIN_LEVEL_IDX,
      p3c_pkg::PIN_OUT_DATA_IDX: idx_mapped = addr_aligned;
      default: idx_mapped = 1'h0;
    endcase
  end

  // Per-pin input path, sampling choice and interrupt qualification.
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : gen_pin
      if (g == p3c_pkg::SERIAL_PIN) begin : gen_serial
        assign sample_en[g] = tick_64hz;
        assign is_input[g] = ~ctrl_q[g][p3c_pkg::DIRECTION_BIT] |
                             ctrl_q[g][p3c_pkg::SERIAL_RX_PIN_SELECT_BIT];
      end else begin : gen_plain
        // With the system clock chosen every cycle samples, so a change is seen one cycle after filtering.
        assign sample_en[g] = ctrl_q[g][p3c_pkg::SAMPLE_CLOCK_SELECT_BIT] | tick_64hz;
        assign is_input[g] = ~ctrl_q[g][p3c_pkg::DIRECTION_BIT];
      end

      p3c_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_async(pin_in[g]),
        .sample_en(sample_en[g]),
        .level(level[g]),
        .changed(changed[g])
      );

      assign event_hit[g] = changed[g] & is_input[g] & ctrl_q[g][p3c_pkg::IRQ_ENABLE_BIT];
    end
  endgenerate

  // Control register file.
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      ctrl_d[i] = ctrl_q[i];
    end
    out_data_d = out_data_q;
    irq_en_d = irq_en_q;
    if (write_strobe && addr_aligned) begin
      unique case (reg_idx)
        p3c_pkg::PIN0_CONTROL_IDX: ctrl_d[0] = pwdata[3:0];
        p3c_pkg::PIN1_CONTROL_IDX: ctrl_d[1] = pwdata[3:0];
        p3c_pkg::PIN2_CONTROL_IDX: ctrl_d[2] = pwdata[3:0];
        p3c_pkg::PIN3_CONTROL_IDX: ctrl_d[3] = pwdata[3:0];
        p3c_pkg::IRQ_ENABLE_IDX: irq_en_d = pwdata[PINS-1:0];
        p3c_pkg::PIN_OUT_DATA_IDX: out_data_d = pwdata[PINS-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < PINS; i++) begin
        ctrl_q[i] <= p3c_pkg::CTRL_RESET;
      end
      out_data_q <= p3c_pkg::OUT_DATA_RESET;
      irq_en_q <= p3c_pkg::IRQ_RESET;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        ctrl_q[i] <= ctrl_d[i];
      end
      out_data_q <= out_data_d;
      irq_en_q <= irq_en_d;
    end
  end

  // Sticky status: a new event in the same cycle as its clear keeps the bit set.
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (write_strobe && addr_aligned && reg_idx == p3c_pkg::IRQ_CLEAR_IDX) begin
      irq_stat_d = irq_stat_q & ~pwdata[PINS-1:0];
    end
    irq_stat_d = irq_stat_d | event_hit;
    irq_d = |(irq_stat_d & irq_en_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= p3c_pkg::IRQ_RESET;
      irq_q <= 1'h0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q <= irq_d;
    end
  end

  // Bus answer: read data and status are prepared in the setup cycle, so every access takes two cycles, setup and access, with no wait state.
  always_comb begin
    prdata_d = 32'h0;
    pready_d = setup_phase;
    pslverr_d = setup_phase & ~idx_mapped;
    if (setup_phase && !pwrite && idx_mapped) begin
      unique case (reg_idx)
        p3c_pkg::IRQ_STATUS_IDX: prdata_d[PINS-1:0] = irq_stat_q;
        p3c_pkg::IRQ_ENABLE_IDX: prdata_d[PINS-1:0] = irq_en_q;
        p3c_pkg::PIN_LEVEL_IDX: prdata_d[PINS-1:0] = level;
        p3c_pkg::PIN_OUT_DATA_IDX: prdata_d[PINS-1:0] = out_data_q;
        default: prdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Pad drive, computed from the next control state so pads change at the same edge as the write lands.
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (!ctrl_d[i][p3c_pkg::DIRECTION_BIT] ||
          (i == p3c_pkg::SERIAL_PIN && ctrl_d[i][p3c_pkg::SERIAL_RX_PIN_SELECT_BIT])) begin
        pin_oe_d[i] = 1'h0;
        pin_out_d[i] = 1'h0;
        pull_d[i] = ~ctrl_d[i][p3c_pkg::PAD_TYPE_BIT];
      end else if (ctrl_d[i][p3c_pkg::PAD_TYPE_BIT]) begin
        // Open drain only ever pulls low; a high data bit releases the pin.
        pin_oe_d[i] = ~out_data_d[i];
        pin_out_d[i] = 1'h0;
        pull_d[i] = 1'h0;
      end else begin
        pin_oe_d[i] = 1'h1;
        pin_out_d[i] = out_data_d[i];
        pull_d[i] = 1'h0;
      end
    end
    srx_d = serial_sel ? level[p3c_pkg::SERIAL_PIN] : p3c_pkg::SERIAL_IDLE_LEVEL;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
      pull_q <= '1;
      srx_q <= p3c_pkg::SERIAL_IDLE_LEVEL;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      pull_q <= pull_d;
      srx_q <= srx_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign pin_pull_en = pull_q;
  assign serial_rx_data = srx_q;
  assign irq = irq_q;

endmodule

`default_nettype wire

// ---- dv/p3c_pads.sv ----
// Pad model: resolves each pin from the block's drive, an external driver and a pull-down.
// Assumes pull-downs; an undriven, unpulled pin toggles every cycle so it never looks stable.
`default_nettype none
module p3c_pads (
  input wire logic pclk,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_pull_en,
  input wire logic [3:0] ext_val,
  input wire logic [3:0] ext_en,
  output logic [3:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flt_q = 1'h0;
  always @(posedge pclk) flt_q <= ~flt_q;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pull_en[i]) pin_in[i] = 1'h0;
      else pin_in[i] = flt_q;
    end
  end
endmodule
`default_nettype wire

// ---- dv/p3c_port_chk.sv ----
// Checker for the port block: APB answers, pad controls, interrupt line, serial input.
// Assumes it is bound into p3c_port and sees only that module's ports.
`default_nettype none
module p3c_port_chk #(
  parameter int unsigned PINS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [p3c_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic [PINS-1:0] pin_pull_en,
  input wire logic serial_rx_data,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Pads change, and irq falls, only at the edge where a write lands, so the cause sits one sample back.
  logic wr_done;
  assign wr_done = psel && penable && pwrite && pready;
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready late");
  a_misaligned_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned not refused");
  a_ctrl_read_zero: assert property (pready && !pwrite && paddr[7:4] == 4'h5 && paddr[1:0] == 2'h0 |->
    prdata == 32'h0 && !pslverr) else $error("control read not zero");
  a_pull_input_only: assert property ((pin_pull_en & pin_oe) == '0)
    else $error("pull on driven pin");
  a_pads_by_write: assert property (!$stable({pin_oe, pin_out, pin_pull_en}) |-> $past(wr_done, 1))
    else $error("pad change without write");
  a_irq_drop_write: assert property ($fell(irq) |-> $past(wr_done, 1))
    else $error("irq dropped without write");
  a_serial_input: assert property (!serial_rx_data |-> !pin_oe[PINS-1])
    else $error("serial pin driven");
  a_reset_values: assert property ($rose(presetn) |-> pin_oe == '0 && pin_pull_en == '1 && !irq)
    else $error("bad values after reset");
  c_irq: cover property ($rose(irq));
  c_serial: cover property (!serial_rx_data);
  c_refused: cover property (pready && pslverr);
endmodule
bind p3c_port p3c_port_chk #(.PINS(PINS)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .pin_out, .pin_oe, .pin_pull_en, .serial_rx_data, .irq);
`default_nettype wire

// ---- dv/p3c_port_bench.sv ----
// Self-checking bench for the port block: registers, pad modes, pin interrupts, serial input.
// Assumes the pad model on the pins and the bound checker; the tick pulses only on request.
`default_nettype none
module p3c_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, tick_64hz = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] ext_val = 4'h0, ext_en = 4'h0;
  logic [31:0] prdata, rd;
  logic [3:0] pin_in, pin_out, pin_oe, pin_pull_en;
  logic pready, pslverr, serial_rx_data, irq, er;
  int mismatches = 0, comparisons = 0, cycles = 0;
  always #25 pclk = ~pclk;
  p3c_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pin_in, .tick_64hz, .pin_out, .pin_oe, .pin_pull_en, .serial_rx_data, .irq);
  p3c_pads pads (.pclk, .pin_out, .pin_oe, .pin_pull_en, .ext_val, .ext_en, .pin_in);
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // A stuck handshake is cut short here rather than hanging the run.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wait_for(input bit ser, input logic exp);
    for (int i = 0; i < 16 && (ser ? serial_rx_data : irq) !== exp; i++) @(posedge pclk);
    chk(32'(ser ? serial_rx_data : irq), 32'(exp), "late");
  endtask
  task automatic tick();
    tick_64hz <= 1'h1;
    @(posedge pclk);
    tick_64hz <= 1'h0;
  endtask
  task automatic t_reset();
    chk(32'(pin_oe), 32'h0, "oe");
    chk(32'(pin_pull_en), 32'hf, "pull");
    chk(32'(irq), 32'h0, "irq");
    chk(32'(serial_rx_data), 32'h1, "serial");
  endtask
  task automatic t_regs();
    apb(1'h0, 8'h54, 32'h0);
    chk(rd, 32'h0, "ctrl read");
    chk(32'(er), 32'h0, "ctrl read err");
    apb(1'h1, 8'h68, 32'h5);
    apb(1'h0, 8'h68, 32'h0);
    chk(rd, 32'h5, "enable readback");
    apb(1'h1, 8'h70, 32'h3);
    apb(1'h0, 8'h70, 32'h0);
    chk(rd, 32'h3, "out data readback");
    apb(1'h1, 8'h51, 32'hf);
    chk(32'(er), 32'h1, "misaligned");
    apb(1'h0, 8'h7c, 32'h0);
    chk(32'(er), 32'h1, "unmapped");
    chk(32'(pin_oe), 32'h0, "ignored write");
  endtask
  task automatic t_modes();
    logic [3:0] m;
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 8; k++) begin
        m = 4'(k >> 1);
        apb(1'h1, 8'h70, 32'({4{k[0]}}));
        apb(1'h1, 8'(8'h50 + 4 * p), 32'(m));
        repeat (2) @(posedge pclk);
        chk(32'(pin_oe[p]), 32'(m[1] && !(m[0] && k[0])), "dir");
        chk(32'(pin_pull_en[p]), 32'(m == 4'h0), "pull");
        chk(32'(pin_out[p] & pin_oe[p]), 32'(m == 4'h2 && k[0]), "drive");
      end
      apb(1'h1, 8'(8'h50 + 4 * p), 32'h0);
    end
  endtask
  task automatic t_irq();
    ext_en <= 4'hf;
    apb(1'h1, 8'h68, 32'h1);
    apb(1'h1, 8'h50, 32'hc);
    ext_val <= 4'h1;
    wait_for(1'h0, 1'h1);
    apb(1'h0, 8'h60, 32'h0);
    chk(rd, 32'h1, "status");
    apb(1'h1, 8'h64, 32'h1);
    wait_for(1'h0, 1'h0);
    apb(1'h1, 8'h68, 32'h0);
    ext_val <= 4'h0;
    repeat (12) @(posedge pclk);
    chk(32'(irq), 32'h0, "masked");
    apb(1'h0, 8'h60, 32'h0);
    chk(rd, 32'h1, "masked status");
    apb(1'h1, 8'h64, 32'h1);
    apb(1'h1, 8'h50, 32'h4);
    apb(1'h1, 8'h68, 32'hf);
    ext_val <= 4'h1;
    repeat (12) @(posedge pclk);
    apb(1'h0, 8'h60, 32'h0);
    chk(rd, 32'h0, "ie off");
  endtask
  task automatic t_tick();
    apb(1'h1, 8'h54, 32'h8);
    apb(1'h1, 8'h5c, 32'h8);
    tick();
    apb(1'h1, 8'h64, 32'hf);
    ext_val <= 4'ha;
    repeat (12) @(posedge pclk);
    chk(32'(irq), 32'h0, "no tick");
    apb(1'h0, 8'h6c, 32'h0);
    chk(rd, 32'ha, "pin level");
    tick();
    wait_for(1'h0, 1'h1);
    apb(1'h0, 8'h60, 32'h0);
    chk(rd, 32'ha, "tick status");
    apb(1'h1, 8'h64, 32'hf);
  endtask
  task automatic t_serial();
    apb(1'h1, 8'h5c, 32'h6);
    repeat (2) @(posedge pclk);
    chk(32'(pin_oe[3]), 32'h0, "forced input");
    ext_val <= 4'h0;
    wait_for(1'h1, 1'h0);
    ext_val <= 4'h8;
    wait_for(1'h1, 1'h1);
    ext_val <= 4'h0;
    apb(1'h1, 8'h5c, 32'h2);
    repeat (2) @(posedge pclk);
    chk(32'(pin_oe[3]), 32'h1, "port use");
    chk(32'(serial_rx_data), 32'h1, "serial idle");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_regs();
    t_modes();
    t_irq();
    t_tick();
    t_serial();
    report_and_stop();
  end
endmodule
`default_nettype wire
